// ==== src/wdma_cmd.sv ====
// write-by-dma command handler, task file over apb
// assumes dma and media pins are asynchronous to pclk
`include "wdma_defines.svh"
`default_nettype none
module wdma_cmd (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// host dma side
	input  wire logic [15:0] host_data_pin,
	input  wire logic        host_strobe_pin,
	input  wire logic        host_crc_pin,
	output logic             dmarq,
	output logic             intrq,
	// media side
	output logic      [15:0] media_word,
	output logic             media_word_valid,
	output logic             media_commit,
	output logic      [47:0] media_lba,
	input  wire logic        media_ack_pin,
	input  wire logic        media_unc_pin
);
	// ********************
	// input synchronisers
	// ********************
	logic [19:0] sync1_ff;
	logic [19:0] sync2_ff;
	logic        strobe_d_ff;
	logic        ack_d_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff    <= 20'h00000;
			sync2_ff    <= 20'h00000;
			strobe_d_ff <= 1'b0;
			ack_d_ff    <= 1'b0;
		end else begin
			sync1_ff    <= {media_unc_pin, media_ack_pin, host_crc_pin, host_strobe_pin, host_data_pin};
			sync2_ff    <= sync1_ff;
			strobe_d_ff <= sync2_ff[16];
			ack_d_ff    <= sync2_ff[18];
		end
	end
	logic [15:0] s_data;
	logic        s_word;
	logic        s_crc;
	logic        s_ack;
	logic        s_unc;
	assign s_data = sync2_ff[15:0];
	assign s_word = sync2_ff[16] & ~strobe_d_ff;
	assign s_crc  = sync2_ff[17];
	assign s_ack  = sync2_ff[18] & ~ack_d_ff;
	assign s_unc  = sync2_ff[19];

	// ********************
	// apb decode
	// ********************
	logic setup;
	logic acc;
	logic wr;
	assign setup = psel & ~penable;
	assign acc   = psel & penable & pready;
	assign wr    = acc & pwrite;

	// ********************
	// state
	// ********************
	wdma_pkg::wdma_state_e state_ff, nxt_state;
	logic [7:0]  cur_ff [4];
	logic [7:0]  prev_ff [4];
	logic [7:0]  nxt_cur [4];
	logic [7:0]  nxt_prev [4];
	logic [7:0]  dev_ff, nxt_dev;
	logic        hob_ff, nxt_hob;
	logic        ext_ff, nxt_ext;
	logic        lbam_ff, nxt_lbam;
	logic [47:0] lba_ff, nxt_lba;
	logic [47:0] last_ff, nxt_last;
	logic [16:0] remain_ff, nxt_remain;
	logic [7:0]  wcnt_ff, nxt_wcnt;
	logic [7:0]  err_ff, nxt_err;
	logic        df_ff, nxt_df;
	logic        intrq_ff, nxt_intrq;
	logic        dmarq_ff, nxt_dmarq;
	logic [15:0] mword_ff, nxt_mword;
	logic        mvalid_ff, nxt_mvalid;
	logic        mcommit_ff, nxt_mcommit;
	logic [47:0] mlba_ff, nxt_mlba;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;

	logic [7:0]  status;
	logic        busy;
	assign busy   = state_ff != wdma_pkg::st_idle;
	assign status = {busy, 1'b1, df_ff, 1'b1, dmarq_ff, 2'b00, err_ff != 8'h00};

	// geometry advance: sector 1..spt, then head, then cylinder
	function automatic logic [47:0] geo_next(input logic [47:0] a);
		logic [47:0] r;
		r = a;
		if (a[7:0] != `WDMA_GEO_SPT) begin
			r[7:0] = a[7:0] + 8'h01;
		end else begin
			r[7:0] = 8'h01;
			if (a[27:24] != `WDMA_GEO_HEADS) begin
				r[27:24] = a[27:24] + 4'h1;
			end else begin
				r[27:24] = 4'h0;
				r[23:8]  = a[23:8] + 16'h0001;
			end
		end
		return r;
	endfunction

	logic [16:0] cnt28;
	logic [16:0] cnt48;
	logic [47:0] a28;
	logic [47:0] a48;
	logic [47:0] rep;
	logic [47:0] endl;
	assign cnt28 = (cur_ff[0] == 8'h00) ? `WDMA_MAX_28 : {9'h000, cur_ff[0]};
	assign cnt48 = ({prev_ff[0], cur_ff[0]} == 16'h0000) ? `WDMA_MAX_EXT : {1'b0, prev_ff[0], cur_ff[0]};
	assign a28   = {20'h00000, dev_ff[3:0], cur_ff[3], cur_ff[2], cur_ff[1]};
	assign a48   = {prev_ff[3], prev_ff[2], prev_ff[1], cur_ff[3], cur_ff[2], cur_ff[1]};
	assign rep   = (err_ff != 8'h00 && ext_ff) ? lba_ff : last_ff;
	assign endl  = a48 + {31'h00000000, cnt48} - 48'h1;

	always_comb begin
		nxt_state   = state_ff;
		nxt_cur     = cur_ff;
		nxt_prev    = prev_ff;
		nxt_dev     = dev_ff;
		nxt_hob     = hob_ff;
		nxt_ext     = ext_ff;
		nxt_lbam    = lbam_ff;
		nxt_lba     = lba_ff;
		nxt_last    = last_ff;
		nxt_remain  = remain_ff;
		nxt_wcnt    = wcnt_ff;
		nxt_err     = err_ff;
		nxt_df      = df_ff;
		nxt_intrq   = intrq_ff;
		nxt_dmarq   = dmarq_ff;
		nxt_mword   = mword_ff;
		nxt_mvalid  = 1'b0;
		nxt_mcommit = 1'b0;
		nxt_mlba    = mlba_ff;
		// status read acknowledges the interrupt
		if (acc && !pwrite && paddr == `WDMA_OFF_STATUS) begin
			nxt_intrq = 1'b0;
		end
		// task file writes are ignored while busy
		if (wr && !busy) begin
			case (paddr)
				`WDMA_OFF_COUNT: begin
					nxt_prev[0] = cur_ff[0];
					nxt_cur[0]  = pwdata[7:0];
					nxt_hob     = 1'b0;
				end
				`WDMA_OFF_LOW: begin
					nxt_prev[1] = cur_ff[1];
					nxt_cur[1]  = pwdata[7:0];
					nxt_hob     = 1'b0;
				end
				`WDMA_OFF_MID: begin
					nxt_prev[2] = cur_ff[2];
					nxt_cur[2]  = pwdata[7:0];
					nxt_hob     = 1'b0;
				end
				`WDMA_OFF_HIGH: begin
					nxt_prev[3] = cur_ff[3];
					nxt_cur[3]  = pwdata[7:0];
					nxt_hob     = 1'b0;
				end
				`WDMA_OFF_DEV: begin
					nxt_dev = pwdata[7:0];
				end
				`WDMA_OFF_DEVCTL: begin
					nxt_hob = pwdata[`WDMA_HOB_BIT];
				end
				`WDMA_OFF_CMD: begin
					nxt_err   = 8'h00;
					nxt_df    = 1'b0;
					nxt_state = wdma_pkg::st_done;
					nxt_wcnt  = 8'h00;
					nxt_lbam  = dev_ff[`WDMA_LBAM_BIT];
					if (pwdata[7:0] == `WDMA_OP_EXT) begin
						nxt_ext    = 1'b1;
						nxt_lba    = a48;
						nxt_last   = a48 - 48'h1;
						nxt_remain = cnt48;
						nxt_lbam   = 1'b1;
						if (endl > `WDMA_MAX_LBA) begin
							nxt_err = `WDMA_ERR_IDN | `WDMA_ERR_ABT;
						end else begin
							nxt_state = wdma_pkg::st_xfer;
						end
					end else if ((pwdata[7:0] & ~`WDMA_OP_RETRY) == `WDMA_OP_28) begin
						nxt_ext    = 1'b0;
						nxt_lba    = a28;
						nxt_last   = a28;
						nxt_remain = cnt28;
						nxt_state  = wdma_pkg::st_xfer;
					end else begin
						nxt_err = `WDMA_ERR_ABT;
					end
				end
				default: begin
				end
			endcase
		end
		case (state_ff)
			wdma_pkg::st_idle: begin
				nxt_dmarq = 1'b0;
			end
			wdma_pkg::st_xfer: begin
				// host dma was set up before the opcode
				nxt_dmarq = 1'b1;
				if (s_crc) begin
					nxt_err   = `WDMA_ERR_CRC | `WDMA_ERR_ABT;
					nxt_dmarq = 1'b0;
					nxt_state = wdma_pkg::st_done;
				end else if (s_word && dmarq_ff) begin
					nxt_mword  = s_data;
					nxt_mvalid = 1'b1;
					nxt_wcnt   = wcnt_ff + 8'h01;
					if (wcnt_ff == `WDMA_WORDS_LAST) begin
						nxt_dmarq   = 1'b0;
						nxt_mcommit = 1'b1;
						nxt_mlba    = lba_ff;
						nxt_state   = wdma_pkg::st_commit;
					end
				end
			end
			wdma_pkg::st_commit: begin
				nxt_dmarq = 1'b0;
				if (s_ack) begin
					if (s_unc) begin
						// stop here, rest is left undone
						nxt_err   = `WDMA_ERR_ABT;
						nxt_df    = 1'b1;
						nxt_state = wdma_pkg::st_done;
					end else begin
						nxt_last   = lba_ff;
						nxt_lba    = (lbam_ff) ? lba_ff + 48'h1 : geo_next(lba_ff);
						nxt_remain = remain_ff - 17'h00001;
						nxt_state  = (remain_ff == 17'h00001) ? wdma_pkg::st_done : wdma_pkg::st_xfer;
					end
				end
			end
			wdma_pkg::st_done: begin
				nxt_dmarq = 1'b0;
				nxt_cur[0] = remain_ff[7:0];
				nxt_cur[1] = rep[7:0];
				nxt_cur[2] = rep[15:8];
				nxt_cur[3] = rep[23:16];
				if (ext_ff) begin
					nxt_prev[0] = remain_ff[15:8];
					nxt_prev[1] = rep[31:24];
					nxt_prev[2] = rep[39:32];
					nxt_prev[3] = rep[47:40];
				end else begin
					nxt_dev = {dev_ff[7:4], rep[27:24]};
				end
				nxt_intrq = 1'b1;
				nxt_state = wdma_pkg::st_idle;
			end
			default: begin
				nxt_state = wdma_pkg::st_idle;
			end
		endcase
	end

	// ********************
	// apb answer
	// ********************
	always_comb begin
		nxt_pready  = setup;
		nxt_pslverr = 1'b0;
		nxt_prdata  = 32'h00000000;
		if (setup && !pwrite) begin
			case (paddr)
				`WDMA_OFF_COUNT: nxt_prdata[7:0]  = hob_ff ? prev_ff[0] : cur_ff[0];
				`WDMA_OFF_LOW:   nxt_prdata[7:0]  = hob_ff ? prev_ff[1] : cur_ff[1];
				`WDMA_OFF_MID:   nxt_prdata[7:0]  = hob_ff ? prev_ff[2] : cur_ff[2];
				`WDMA_OFF_HIGH:  nxt_prdata[7:0]  = hob_ff ? prev_ff[3] : cur_ff[3];
				`WDMA_OFF_DEV:   nxt_prdata[7:0]  = dev_ff;
				`WDMA_OFF_DEVCTL: nxt_prdata[7:0] = {hob_ff, 7'h00};
				`WDMA_OFF_STATUS: nxt_prdata[7:0] = status;
				`WDMA_OFF_ERROR: nxt_prdata[7:0]  = err_ff;
				`WDMA_OFF_CMD:   nxt_prdata[7:0]  = 8'h00;
				default:         nxt_pslverr      = 1'b1;
			endcase
		end else if (setup) begin
			nxt_pslverr = paddr > `WDMA_OFF_DEV || paddr[1:0] != 2'b00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= wdma_pkg::st_idle;
			for (int i = 0; i < 4; i++) begin
				cur_ff[i]  <= 8'h00;
				prev_ff[i] <= 8'h00;
			end
			dev_ff     <= 8'h00;
			hob_ff     <= 1'b0;
			ext_ff     <= 1'b0;
			lbam_ff    <= 1'b0;
			lba_ff     <= 48'h0;
			last_ff    <= 48'h0;
			remain_ff  <= 17'h00000;
			wcnt_ff    <= 8'h00;
			err_ff     <= 8'h00;
			df_ff      <= 1'b0;
			intrq_ff   <= 1'b0;
			dmarq_ff   <= 1'b0;
			mword_ff   <= 16'h0000;
			mvalid_ff  <= 1'b0;
			mcommit_ff <= 1'b0;
			mlba_ff    <= 48'h0;
			prdata_ff  <= 32'h00000000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cur_ff     <= nxt_cur;
			prev_ff    <= nxt_prev;
			dev_ff     <= nxt_dev;
			hob_ff     <= nxt_hob;
			ext_ff     <= nxt_ext;
			lbam_ff    <= nxt_lbam;
			lba_ff     <= nxt_lba;
			last_ff    <= nxt_last;
			remain_ff  <= nxt_remain;
			wcnt_ff    <= nxt_wcnt;
			err_ff     <= nxt_err;
			df_ff      <= nxt_df;
			intrq_ff   <= nxt_intrq;
			dmarq_ff   <= nxt_dmarq;
			mword_ff   <= nxt_mword;
			mvalid_ff  <= nxt_mvalid;
			mcommit_ff <= nxt_mcommit;
			mlba_ff    <= nxt_mlba;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign dmarq            = dmarq_ff;
	assign intrq            = intrq_ff;
	assign media_word       = mword_ff;
	assign media_word_valid = mvalid_ff;
	assign media_commit     = mcommit_ff;
	assign media_lba        = mlba_ff;
endmodule // wdma_cmd
`default_nettype wire

// ==== src/wdma_defines.svh ====
// constants of the write-by-dma command handler
// assumes a 200 mhz pclk and an apb master in front
// What this block does
// - opcode 35h starts the extended 48-bit write-by-dma command
// - sector data is committed to media once it is all received
// - payload moves as 16-bit words, one word per transfer
// - transfers happen only while the dma request is raised
// - exactly one interrupt per command, after transfer ends and status settles
// - an uncorrectable error stops the write at the failing sector
// - extended count: current byte low bits, previous byte high bits
// - extended count of zero means 65536 sectors
// - extended address: current bytes low half, previous bytes high half
// - extended error returns failing address, byte select picks halves
// - 28-bit address mode takes bits 24..27 from the head field
// - 28-bit opcode retry bit is ignored
// - 28-bit end: count register holds sectors not transferred
// - 28-bit address mode end: last transferred address returned
// - 28-bit geometry mode end: last cylinder, head, sector returned
// - opcodes cah and cbh start the 28-bit write-by-dma command
// - 28-bit count of zero means 256 sectors
`ifndef WDMA_DEFINES_SVH
`define WDMA_DEFINES_SVH
// ********************
// register offsets
// ********************
`define WDMA_OFF_CMD    8'h00
`define WDMA_OFF_DEVCTL 8'h04
`define WDMA_OFF_COUNT  8'h08
`define WDMA_OFF_LOW    8'h0c
`define WDMA_OFF_MID    8'h10
`define WDMA_OFF_HIGH   8'h14
`define WDMA_OFF_DEV    8'h18
`define WDMA_OFF_STATUS 8'h1c
`define WDMA_OFF_ERROR  8'h20
// ********************
// opcodes and fields
// ********************
`define WDMA_OP_EXT     8'h35
`define WDMA_OP_28      8'hca
`define WDMA_OP_RETRY   8'h01
`define WDMA_HOB_BIT    7
`define WDMA_LBAM_BIT   6
`define WDMA_ERR_CRC    8'h80
`define WDMA_ERR_IDN    8'h10
`define WDMA_ERR_ABT    8'h04
`define WDMA_WORDS_LAST 8'hff
`define WDMA_MAX_EXT    17'h10000
`define WDMA_MAX_28     17'h00100
`define WDMA_MAX_LBA    48'h0000_2540_be3f
`define WDMA_GEO_SPT    8'h3f
`define WDMA_GEO_HEADS  4'hf
`endif

// ==== src/wdma_pkg.sv ====
// types of the write-by-dma command handler
// assumes the defines header is compiled alongside
`default_nettype none
package wdma_pkg;
	typedef enum logic [1:0] {st_idle, st_xfer, st_commit, st_done} wdma_state_e;
	typedef logic [47:0] wdma_lba_t;
endpackage
`default_nettype wire

// ==== bench/wdma_cmd_assertions.sv ====
// checker of the write-by-dma command handler
// assumes it is bound onto wdma_cmd, one pclk domain
`default_nettype none
module wdma_cmd_checker (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// dma and media
	input wire logic        dmarq,
	input wire logic        intrq,
	input wire logic        media_word_valid,
	input wire logic        media_commit,
	input wire logic        media_ack_pin,
	input wire logic        media_unc_pin
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic stat_rd;
	assign stat_rd = psel && penable && pready && !pwrite && paddr == 8'h1c;
	// ********************
	// properties
	// ********************
	property p_start;
		psel && penable && pready && pwrite && paddr == 8'h00 && (pwdata[7:0] == 8'h35 || pwdata[7:1] == 7'h65)
		|-> ##[1:2] dmarq;
	endproperty
	property p_word_qual;
		media_word_valid |-> $past(dmarq, 1) || $past(dmarq, 2);
	endproperty
	property p_word_single;
		media_word_valid |=> !media_word_valid;
	endproperty
	property p_commit;
		media_commit |=> !media_word_valid [*4];
	endproperty
	property p_irq_after;
		$rose(intrq) |-> !dmarq;
	endproperty
	// level held until a status read; a completion while it is high shows no new edge
	property p_irq_hold;
		intrq |=> intrq || $past(stat_rd);
	endproperty
	property p_unc_stop;
		$rose(media_ack_pin) && media_unc_pin |-> !dmarq [*8];
	endproperty
	property p_status;
		psel && penable && pready && !pwrite && paddr == 8'h1c && intrq |-> (prdata[7:0] & 8'hd8) == 8'h50;
	endproperty
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	// ********************
	// assertions
	// ********************
	a_start: assert property (p_start) else $error("no dma request after opcode");
	a_word_qual: assert property (p_word_qual) else $error("word taken without request");
	a_word_single: assert property (p_word_single) else $error("word pulse too long");
	a_commit: assert property (p_commit) else $error("word after commit");
	a_irq_after: assert property (p_irq_after) else $error("interrupt during transfer");
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
	a_unc_stop: assert property (p_unc_stop) else $error("transfer after failed sector");
	a_status: assert property (p_status) else $error("bad completion status");
	a_ready: assert property (p_ready) else $error("apb answer late");
	c_irq: cover property ($rose(intrq));
	c_commit: cover property (media_commit);
	c_unc: cover property ($rose(media_ack_pin) && media_unc_pin);
endmodule // wdma_cmd_checker
bind wdma_cmd wdma_cmd_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .dmarq, .intrq, .media_word_valid, .media_commit, .media_ack_pin, .media_unc_pin);
`default_nettype wire

// ==== bench/wdma_host_model.sv ====
// host dma channel model: one word per strobe while requested
// assumes the bench sets slow before issuing an opcode
`default_nettype none
module wdma_host_model (
	// control
	input wire logic         pclk,
	input wire logic         dmarq,
	input wire logic         slow,
	// dma pins
	output var logic [15:0] host_data_pin,
	output var logic        host_strobe_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] seq;
	initial begin
		seq = 16'h0000;
		host_data_pin = 16'h0000;
		host_strobe_pin = 1'b0;
		forever begin
			repeat (slow ? 8 : 5) @(posedge pclk);
			// strobe only once the word has stood a full gap
			if (dmarq && host_data_pin === seq) begin
				host_strobe_pin <= 1'b1;
				repeat (slow ? 8 : 5) @(posedge pclk);
				host_strobe_pin <= 1'b0;
				seq = seq + 16'h0001;
				host_data_pin <= seq;
			end else begin
				// idle bus shows no stale word
				host_data_pin <= dmarq ? seq : ~seq;
			end
		end
	end
endmodule // wdma_host_model
`default_nettype wire

// ==== bench/test_wdma_cmd.sv ====
// bench of the write-by-dma command handler
// assumes the host model feeds words; media acks come from here
`default_nettype none
module test_wdma_cmd;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
	logic        host_strobe_pin, host_crc_pin, dmarq, intrq;
	logic        media_word_valid, media_commit, media_ack_pin, media_unc_pin;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] host_data_pin, media_word;
	logic [47:0] media_lba;
	int          fail_count, total_checks, words, w0;
	wdma_cmd i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.host_data_pin, .host_strobe_pin, .host_crc_pin, .dmarq, .intrq, .media_word, .media_word_valid,
		.media_commit, .media_lba, .media_ack_pin, .media_unc_pin);
	wdma_host_model i_host (.pclk, .dmarq, .slow, .host_data_pin, .host_strobe_pin);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// every accepted word carries the model's running count
	always @(posedge pclk) begin
		if (media_word_valid === 1'b1) begin
			chk(media_word, words[15:0]);
			words <= words + 1;
		end
	end
	// ********************
	// tasks
	// ********************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// slow media would hide a hang, so every wait is bounded
	task automatic wait_hi(ref logic s);
		int k;
		k = 0;
		while (s !== 1'b1 && k < 6000) begin
			@(posedge pclk);
			k++;
		end
		if (k == 6000) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic load(input logic [7:0] c, l, m, h);
		apb(1'b1, 8'h08, {24'h0, c});
		apb(1'b1, 8'h0c, {24'h0, l});
		apb(1'b1, 8'h10, {24'h0, m});
		apb(1'b1, 8'h14, {24'h0, h});
	endtask
	task automatic sector(input logic unc, input logic [47:0] lba);
		wait_hi(media_commit);
		chk(media_lba, lba);
		media_unc_pin <= unc;
		media_ack_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		media_ack_pin <= 1'b0;
		media_unc_pin <= 1'b0;
	endtask
	// ********************
	// sequence
	// ********************
	initial begin
		{presetn, psel, penable, pwrite, host_crc_pin, media_ack_pin, media_unc_pin} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		slow = 1'b1;
		fail_count = 0;
		total_checks = 0;
		words = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(8'h1c, 32'h50);
		rdchk(8'h20, 32'h00);
		apb(1'b0, 8'h24, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("test reset and map done");
		w0 = words;
		load(8'h02, 8'h11, 8'h22, 8'h33);
		apb(1'b1, 8'h18, 32'h45);
		apb(1'b1, 8'h00, 32'hcb);
		sector(1'b0, 48'h5332211);
		sector(1'b0, 48'h5332212);
		wait_hi(intrq);
		chk(words - w0, 512);
		rdchk(8'h1c, 32'h50);
		rdchk(8'h08, 32'h00);
		rdchk(8'h0c, 32'h12);
		rdchk(8'h10, 32'h22);
		rdchk(8'h14, 32'h33);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd[3:0], 4'h5);
		$display("test short write done");
		w0 = words;
		slow <= 1'b0;
		load(8'h01, 8'h01, 8'h00, 8'h00);
		load(8'h03, 8'h40, 8'h00, 8'h00);
		apb(1'b1, 8'h18, 32'h40);
		apb(1'b1, 8'h00, 32'h35);
		sector(1'b0, 48'h0100_0040);
		sector(1'b1, 48'h0100_0041);
		wait_hi(intrq);
		chk(words - w0, 512);
		rdchk(8'h1c, 32'h71);
		rdchk(8'h20, 32'h04);
		rdchk(8'h08, 32'h02);
		rdchk(8'h0c, 32'h41);
		apb(1'b1, 8'h04, 32'h80);
		rdchk(8'h08, 32'h01);
		rdchk(8'h0c, 32'h01);
		$display("test extended error done");
		w0 = words;
		load(8'h02, 8'h3f, 8'h05, 8'h00);
		apb(1'b1, 8'h18, 32'h02);
		apb(1'b1, 8'h00, 32'hca);
		sector(1'b0, 48'h200_053f);
		sector(1'b0, 48'h300_0501);
		wait_hi(intrq);
		chk(words - w0, 512);
		rdchk(8'h1c, 32'h50);
		rdchk(8'h08, 32'h00);
		rdchk(8'h0c, 32'h01);
		rdchk(8'h10, 32'h05);
		rdchk(8'h18, 32'h03);
		$display("test geometry write done");
		apb(1'b1, 8'h00, 32'h20);
		wait_hi(intrq);
		rdchk(8'h1c, 32'h51);
		rdchk(8'h20, 32'h04);
		$display("test unknown opcode done");
		wrap_up();
	end
endmodule // test_wdma_cmd
`default_nettype wire
